// [pids_regs.sv]
// What this block does
// - page received interrupt enable, reset zero
// - parallel detect fault enable, reset zero
// - partner acknowledge enable, reset zero
// - link down enable, reset zero
// - remote fault enable, reset zero
// - link up enable, reset zero
// - jabber flag set on jabber
// - receive error flag set on error
// - page received flag set on page
// - parallel detect fault flag set
// - partner acknowledge flag set
// - link down flag set
// - remote fault flag set
// - link up flag set
// - start bit self clears after test
// - results valid once start bit clear
// - result code normal/open/short/failed
// - short cable bit under ten metres
// - pause capability bit, upper bits zero
// - receive polarity reversed bit
// - interrupt pin polarity control bit
`timescale 1ns/1ps
module pids_regs
  import pids_pkg::*;
(
  // clock and reset
  clk,
  rst_n,
  // register access from the management frame engine
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  reg_rvalid,
  // link events, one cycle pulses
  evt_jabber,
  evt_rx_error,
  evt_page_rcvd,
  evt_pd_fault,
  evt_lp_ack,
  evt_link_down,
  evt_remote_fault,
  evt_link_up,
  // live status
  sts_pause,
  sts_link,
  sts_pol_rev,
  // cable diagnostic engine
  cable_diagnostic_start,
  cable_diagnostic_done,
  cable_diagnostic_result,
  cable_diagnostic_short,
  cable_diagnostic_count,
  // interrupt pin
  int_pin
);

  // ----------------------------------------------------------------
  // port declarations
  // ----------------------------------------------------------------
  input  wire logic                  clk;
  input  wire logic                  rst_n;
  input  wire logic [4:0]            reg_addr;
  input  wire logic                  reg_wr;
  input  wire logic                  reg_rd;
  input  wire logic [15:0]           reg_wdata;
  output logic [15:0]                reg_rdata;
  output logic                       reg_rvalid;
  input  wire logic                  evt_jabber;
  input  wire logic                  evt_rx_error;
  input  wire logic                  evt_page_rcvd;
  input  wire logic                  evt_pd_fault;
  input  wire logic                  evt_lp_ack;
  input  wire logic                  evt_link_down;
  input  wire logic                  evt_remote_fault;
  input  wire logic                  evt_link_up;
  input  wire logic                  sts_pause;
  input  wire logic                  sts_link;
  input  wire logic                  sts_pol_rev;
  output logic                       cable_diagnostic_start;
  input  wire logic                  cable_diagnostic_done;
  input  wire logic [1:0]            cable_diagnostic_result;
  input  wire logic                  cable_diagnostic_short;
  input  wire logic [DIAG_CNT_W-1:0] cable_diagnostic_count;
  output logic                       int_pin;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [INT_EN_W-1:0]   int_en;
    logic                  int_level;
    logic [DIAG_RSV_W-1:0] diag_rsv;
    logic [15:0]           rdata;
    logic                  rvalid;
    logic                  int_pin;
  } pids_regs_state_type;

  pids_regs_state_type s_q;
  pids_regs_state_type s_d;

  logic [FLAG_COUNT-1:0] evt_vec;
  logic [FLAG_COUNT-1:0] flag_vec;
  logic                  flag_clear;
  logic                  wr_int;
  logic                  wr_cable;
  logic                  wr_ctrl2;
  logic                  diag_start_req;
  logic                  diag_busy;
  logic [1:0]            diag_result;
  logic                  diag_short;
  logic [DIAG_CNT_W-1:0] diag_count;
  logic                  int_active;
  logic [15:0]           rd_mux;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // write strobes per register
  assign wr_int   = reg_wr && (reg_addr == ADDR_INT_CTRL);
  assign wr_cable = reg_wr && (reg_addr == ADDR_CABLE);
  assign wr_ctrl2 = reg_wr && (reg_addr == ADDR_PHY_CTRL2);

  assign flag_clear = reg_rd && (reg_addr == ADDR_INT_CTRL);

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  // bit order matches the flag field of the interrupt register
  assign evt_vec = {evt_jabber, evt_rx_error, evt_page_rcvd, evt_pd_fault,
                    evt_lp_ack, evt_link_down, evt_remote_fault, evt_link_up};

  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
    pids_flag_cell u_flag (
      .clk      (clk),
      .rst_n    (rst_n),
      .event_in (evt_vec[i]),
      .clear_in (flag_clear),
      .flag     (flag_vec[i])
    );
  end

  // ----------------------------------------------------------------
  // cable diagnostic
  // ----------------------------------------------------------------
  // write of one starts test
  assign diag_start_req = wr_cable && reg_wdata[DIAG_EN_BIT];

  pids_cable_diag u_diag (
    .clk         (clk),
    .rst_n       (rst_n),
    .start_req   (diag_start_req),
    .test_done   (cable_diagnostic_done),
    .test_result (cable_diagnostic_result),
    .test_short  (cable_diagnostic_short),
    .test_count  (cable_diagnostic_count),
    .busy        (diag_busy),
    .start_pulse (cable_diagnostic_start),
    .result      (diag_result),
    .short_cable (diag_short),
    .fault_count (diag_count)
  );

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  // enabled flags assert pin
  // jabber and receive error flags have no enable here, so never gate
  assign int_active = |(flag_vec[INT_EN_W-1:0] & s_q.int_en);

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  // unmapped offsets read as zero; cable register reserved bits 11:9 read back as written, other reserved bits read as zero
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      ADDR_INT_CTRL: begin
        rd_mux[INT_EN_LSB +: INT_EN_W] = s_q.int_en;
        rd_mux[FLAG_COUNT-1:0]         = flag_vec;
      end
      ADDR_CABLE: begin
        rd_mux[DIAG_EN_BIT]                = diag_busy;
        rd_mux[DIAG_RES_LSB +: 2]          = diag_result;
        rd_mux[DIAG_SHORT_BIT]             = diag_short;
        rd_mux[DIAG_RSV_LSB +: DIAG_RSV_W] = s_q.diag_rsv;
        rd_mux[DIAG_CNT_W-1:0]             = diag_count;
      end
      ADDR_PHY_CTRL1: begin
        rd_mux[PC1_PAUSE_BIT] = sts_pause;
        rd_mux[PC1_LINK_BIT]  = sts_link;
        rd_mux[PC1_POL_BIT]   = sts_pol_rev;
      end
      ADDR_PHY_CTRL2: begin
        rd_mux[PC2_LEVEL_BIT] = s_q.int_level;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // writes to read-only fields are dropped without notice
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = reg_rd;
    if (reg_rd) begin
      s_d.rdata = rd_mux;
    end
    if (wr_int) begin
      s_d.int_en = reg_wdata[INT_EN_LSB +: INT_EN_W];
    end
    if (wr_cable) begin
      s_d.diag_rsv = reg_wdata[DIAG_RSV_LSB +: DIAG_RSV_W];
    end
    if (wr_ctrl2) begin
      s_d.int_level = reg_wdata[PC2_LEVEL_BIT];
    end
    s_d.int_pin = s_q.int_level ? int_active : !int_active;
  end

  // state register; pin idles high since level resets to active low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{int_en: INT_EN_RST, int_level: LEVEL_RST, diag_rsv: DIAG_RSV_RST,
               rdata: RDATA_RST, rvalid: 1'b0, int_pin: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata  = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign int_pin    = s_q.int_pin;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_int;
    reg_rd && (reg_addr == ADDR_INT_CTRL);
  endsequence

  sequence s_rd_ctrl1;
    reg_rd && (reg_addr == ADDR_PHY_CTRL1);
  endsequence

  a_rd_answer: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read answer not one cycle later");

  a_en_write_back: assert property (wr_int |=> s_q.int_en == $past(reg_wdata[13:8]))
    else $error("interrupt enables not stored");

  a_flag_read_clear: assert property (s_rd_int and (evt_vec == 8'h00) |=> flag_vec == 8'h00)
    else $error("flags not cleared by read");

  a_flag_no_gate: assert property (evt_link_up && s_q.int_en[0] == 1'b0 |=> flag_vec[0])
    else $error("flag depends on enable");

  a_pin_high_level: assert property (s_q.int_level && int_active && !wr_ctrl2 |=> int_pin)
    else $error("active high pin not asserted");

  a_pin_low_level: assert property (!s_q.int_level && int_active |=> !int_pin)
    else $error("active low pin not asserted");

  a_pin_idle_en_off: assert property (s_q.int_en == 6'h00 && !s_q.int_level |=> int_pin)
    else $error("pin asserted with enables clear");

  a_pause_readback: assert property (s_rd_ctrl1 |=> reg_rdata[9] == $past(sts_pause)
                                     && reg_rdata[15:10] == 6'h00)
    else $error("pause bit or upper bits wrong");

  a_polarity_read: assert property (s_rd_ctrl1 |=> reg_rdata[7] == $past(sts_pol_rev))
    else $error("polarity bit wrong");

  a_diag_valid_read: assert property (reg_rd && reg_addr == ADDR_CABLE && !diag_busy
                                      |=> reg_rdata[15] == 1'b0
                                      && reg_rdata[8:0] == $past(diag_count))
    else $error("diagnostic results not shown when done");

  a_short_readback: assert property (reg_rd && reg_addr == ADDR_CABLE
                                     |=> reg_rdata[12] == $past(diag_short))
    else $error("short cable bit wrong");

  a_flag_readback: assert property (s_rd_int |=> reg_rdata[7:0] == $past(flag_vec))
    else $error("flag field not read back as latched");

  a_result_readback: assert property (reg_rd && reg_addr == ADDR_CABLE
                                      |=> reg_rdata[14:13] == $past(diag_result))
    else $error("result code not read back");

  a_pin_high_idle: assert property (s_q.int_level && !int_active |=> !int_pin)
    else $error("active high pin asserted while idle");

  a_level_write: assert property (wr_ctrl2 |=> s_q.int_level == $past(reg_wdata[9]))
    else $error("pin level bit not stored");

  a_level_readback: assert property (reg_rd && reg_addr == ADDR_PHY_CTRL2
                                     |=> reg_rdata == {6'h00, $past(s_q.int_level), 9'h000})
    else $error("pin level register read wrong");

  a_start_on_write: assert property (diag_start_req && !diag_busy
                                     |=> cable_diagnostic_start)
    else $error("idle start write did not launch test");

  a_rvalid_read_only: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without read");

endmodule

// [pids_pkg.sv]
package pids_pkg;

  // ----------------------------------------------------------------
  // register offsets on the management interface
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_INT_CTRL  = 5'h1b;
  localparam logic [4:0] ADDR_CABLE     = 5'h1d;
  localparam logic [4:0] ADDR_PHY_CTRL1 = 5'h1e;
  localparam logic [4:0] ADDR_PHY_CTRL2 = 5'h1f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLAG_COUNT      = 8;
  localparam int INT_EN_LSB      = 8;
  localparam int INT_EN_W        = 6;
  localparam int DIAG_EN_BIT     = 15;
  localparam int DIAG_RES_LSB    = 13;
  localparam int DIAG_SHORT_BIT  = 12;
  localparam int DIAG_RSV_LSB    = 9;
  localparam int DIAG_RSV_W      = 3;
  localparam int DIAG_CNT_W      = 9;
  localparam int PC1_PAUSE_BIT   = 9;
  localparam int PC1_LINK_BIT    = 8;
  localparam int PC1_POL_BIT     = 7;
  localparam int PC2_LEVEL_BIT   = 9;

  // ----------------------------------------------------------------
  // values after reset and result codes
  // ----------------------------------------------------------------
  localparam logic                  FLAG_RST     = 1'b0;
  localparam logic [INT_EN_W-1:0]   INT_EN_RST   = 6'h00;
  localparam logic                  LEVEL_RST    = 1'b0;
  localparam logic [DIAG_RSV_W-1:0] DIAG_RSV_RST = 3'h0;
  localparam logic [1:0]            DIAG_RES_RST = 2'h0;
  localparam logic [DIAG_CNT_W-1:0] DIAG_CNT_RST = 9'h000;
  localparam logic [15:0]           RDATA_RST    = 16'h0000;
  localparam logic [1:0]            RES_NORMAL   = 2'h0;
  localparam logic [1:0]            RES_OPEN     = 2'h1;
  localparam logic [1:0]            RES_SHORT    = 2'h2;
  localparam logic [1:0]            RES_FAILED   = 2'h3;

endpackage

// [pids_flag_cell.sv]
`timescale 1ns/1ps
module pids_flag_cell
  import pids_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // event in, read clear in
  input  wire logic event_in,
  input  wire logic clear_in,
  // sticky flag
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } pids_flag_state_type;

  pids_flag_state_type s_q;
  pids_flag_state_type s_d;

  // set is applied after clear so an event never gets lost
  always_comb begin
    s_d = s_q;
    if (clear_in) begin
      s_d.flag = 1'b0;
    end
    if (event_in) begin
      s_d.flag = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.flag <= FLAG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_set_wins_clear: assert property (event_in |=> flag)
    else $error("event lost against clear");
  a_clear_no_event: assert property (clear_in && !event_in |=> !flag)
    else $error("flag survived read clear");

endmodule

// [pids_cable_diag.sv]
`timescale 1ns/1ps
module pids_cable_diag
  import pids_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // start request from register write
  input  wire logic                  start_req,
  // analog test engine
  input  wire logic                  test_done,
  input  wire logic [1:0]            test_result,
  input  wire logic                  test_short,
  input  wire logic [DIAG_CNT_W-1:0] test_count,
  // state seen by registers and engine
  output logic                       busy,
  output logic                       start_pulse,
  output logic [1:0]                 result,
  output logic                       short_cable,
  output logic [DIAG_CNT_W-1:0]      fault_count
);

  typedef enum logic {DIAG_IDLE, DIAG_RUN} pids_diag_phase_type;

  typedef struct packed {
    pids_diag_phase_type   phase;
    logic                  start_pulse;
    logic [1:0]            result;
    logic                  short_cable;
    logic [DIAG_CNT_W-1:0] count;
  } pids_diag_state_type;

  pids_diag_state_type s_q;
  pids_diag_state_type s_d;

  // test sequencer; a start while running is ignored
  always_comb begin
    s_d = s_q;
    s_d.start_pulse = 1'b0;
    case (s_q.phase)
      DIAG_IDLE: begin
        if (start_req) begin
          s_d.phase       = DIAG_RUN;
          s_d.start_pulse = 1'b1;
        end
      end
      DIAG_RUN: begin
        if (test_done) begin
          s_d.phase       = DIAG_IDLE;
          s_d.result      = test_result;
          s_d.short_cable = test_short;
          s_d.count       = test_count;
        end
      end
      default: begin
        s_d.phase = DIAG_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{phase: DIAG_IDLE, start_pulse: 1'b0, result: DIAG_RES_RST,
               short_cable: 1'b0, count: DIAG_CNT_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy        = (s_q.phase == DIAG_RUN);
  assign start_pulse = s_q.start_pulse;
  assign result      = s_q.result;
  assign short_cable = s_q.short_cable;
  assign fault_count = s_q.count;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_test_ends;
    busy && test_done;
  endsequence

  a_diag_self_clear: assert property (s_test_ends |=> !busy)
    else $error("enable bit not cleared after test");
  a_diag_result_kept: assert property (s_test_ends |=> result == $past(test_result))
    else $error("result code not latched");
  a_diag_start_pulse: assert property (!busy && start_req |=> busy && start_pulse ##1 !start_pulse)
    else $error("start did not launch test");

endmodule

// [pids_diag_model.sv]
`timescale 1ns/1ps
module pids_diag_model
  import pids_pkg::*;
(
  // clock and reset
  clk,
  rst_n,
  // test setup chosen by the bench
  delay,
  code,
  short_in,
  count_in,
  // engine side of the register block
  start,
  done,
  result,
  short_cable,
  count,
  // launches seen so far
  starts
);
  input  wire logic                  clk;
  input  wire logic                  rst_n;
  input  wire logic [7:0]            delay;
  input  wire logic [1:0]            code;
  input  wire logic                  short_in;
  input  wire logic [DIAG_CNT_W-1:0] count_in;
  input  wire logic                  start;
  output logic                       done;
  output logic [1:0]                 result;
  output logic                       short_cable;
  output logic [DIAG_CNT_W-1:0]      count;
  output logic [7:0]                 starts;

  typedef struct packed {
    logic       run;
    logic [7:0] cnt;
    logic [7:0] starts;
    logic       done;
  } pids_model_type;

  pids_model_type state_q;
  pids_model_type state_d;

  // test runs, then ends: a start while running does not relaunch
  always_comb begin
    state_d = state_q;
    state_d.done = 1'b0;
    if (start) begin
      state_d.starts = state_q.starts + 8'h01;
    end
    if (start && !state_q.run) begin
      state_d.run = 1'b1;
      state_d.cnt = delay;
    end else if (state_q.run && state_q.cnt == 8'h00) begin
      state_d.run  = 1'b0;
      state_d.done = 1'b1;
    end else if (state_q.run) begin
      state_d.cnt = state_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // results are only valid with done; otherwise the inverse, so a stray sample shows
  assign done        = state_q.done;
  assign result      = state_q.done ? code : ~code;
  assign short_cable = state_q.done ? short_in : ~short_in;
  assign count       = state_q.done ? count_in : ~count_in;
  assign starts      = state_q.starts;
endmodule

// [phy_irq_diag_status_regs_test.sv]
`timescale 1ns/1ps
module phy_irq_diag_status_regs_test;
  import pids_pkg::*;

  logic                  clk;
  logic                  rst_n;
  logic [4:0]            reg_addr;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [15:0]           reg_wdata;
  logic [15:0]           reg_rdata;
  logic                  reg_rvalid;
  logic [7:0]            evt;
  logic [2:0]            sts;
  logic                  d_start;
  logic                  d_done;
  logic [1:0]            d_result;
  logic                  d_short;
  logic [DIAG_CNT_W-1:0] d_count;
  logic [7:0]            delay;
  logic [1:0]            code;
  logic                  short_in;
  logic [DIAG_CNT_W-1:0] count_in;
  logic [7:0]            starts;
  logic                  int_pin;
  logic [15:0]           rd;
  int                    num_errors;
  int                    checked;

  pids_regs DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .evt_jabber(evt[7]), .evt_rx_error(evt[6]), .evt_page_rcvd(evt[5]),
    .evt_pd_fault(evt[4]), .evt_lp_ack(evt[3]), .evt_link_down(evt[2]),
    .evt_remote_fault(evt[1]), .evt_link_up(evt[0]), .sts_pause(sts[2]),
    .sts_link(sts[1]), .sts_pol_rev(sts[0]), .cable_diagnostic_start(d_start),
    .cable_diagnostic_done(d_done), .cable_diagnostic_result(d_result),
    .cable_diagnostic_short(d_short), .cable_diagnostic_count(d_count), .int_pin(int_pin));

  pids_diag_model engine (
    .clk(clk), .rst_n(rst_n), .delay(delay), .code(code), .short_in(short_in),
    .count_in(count_in), .start(d_start), .done(d_done), .result(d_result),
    .short_cable(d_short), .count(d_count), .starts(starts));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // answer stands one cycle, so it is taken just after the read edge
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check1(reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    evt <= 8'h01 << i;
    @(posedge clk);
    evt <= 8'h00;
  endtask

  task automatic pin_after_edge(input logic exp);
    @(posedge clk);
    #1;
    check1(int_pin, exp);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [4:0] addrs [5];
    addrs = '{5'h1b, 5'h1d, 5'h1e, 5'h1f, 5'h00};
    check1(int_pin, 1'b1);
    foreach (addrs[k]) begin
      read_reg(addrs[k], rd);
      check16(rd, 16'h0000);
    end
  endtask

  task automatic t_access;
    write_reg(5'h1b, 16'hffff);
    read_reg(5'h1b, rd);
    check16(rd, 16'h3f00);
    write_reg(5'h1e, 16'hffff);
    read_reg(5'h1e, rd);
    check16(rd, 16'h0000);
    write_reg(5'h05, 16'hffff);
    read_reg(5'h05, rd);
    check16(rd, 16'h0000);
    write_reg(5'h1b, 16'h0000);
  endtask

  task automatic t_flags;
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      read_reg(5'h1b, rd);
      check16(rd, 16'h0001 << i);
      read_reg(5'h1b, rd);
      check16(rd, 16'h0000);
      check1(int_pin, 1'b1);
    end
    // event and read clear in the same cycle: the set must win
    fork
      pulse(3);
      read_reg(5'h1b, rd);
    join
    check16(rd, 16'h0000);
    read_reg(5'h1b, rd);
    check16(rd, 16'h0008);
  endtask

  task automatic t_irq;
    for (int j = 0; j < 6; j++) begin
      write_reg(5'h1b, 16'h0100 << j);
      pulse(j);
      pin_after_edge(1'b0);
      read_reg(5'h1b, rd);
      check16(rd, (16'h0100 << j) | (16'h0001 << j));
      pin_after_edge(1'b1);
    end
    write_reg(5'h1f, 16'hffff);
    read_reg(5'h1f, rd);
    check16(rd, 16'h0200);
    pin_after_edge(1'b0);
    pulse(5);
    pin_after_edge(1'b1);
    read_reg(5'h1b, rd);
    write_reg(5'h1b, 16'h3f00);
    pulse(7);
    pin_after_edge(1'b0);
    read_reg(5'h1b, rd);
    check16(rd, 16'h3f80);
    write_reg(5'h1f, 16'h0000);
    write_reg(5'h1b, 16'h0000);
  endtask

  task automatic t_status;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      sts <= k[2:0];
      read_reg(5'h1e, rd);
      check16(rd, {6'h00, k[2:0], 7'h00});
    end
  endtask

  task automatic t_diag;
    int n;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      code     <= c[1:0];
      short_in <= c[0];
      count_in <= 9'h0a5 + c[8:0];
      delay    <= 8'h03 + 8'(c * 20);
      write_reg(5'h1d, 16'h8000);
      read_reg(5'h1d, rd);
      check1(rd[15], 1'b1);
      write_reg(5'h1d, 16'h8000);
      write_reg(5'h1d, 16'h0000);
      n = 0;
      read_reg(5'h1d, rd);
      while (rd[15] !== 1'b0 && n < 300) begin
        read_reg(5'h1d, rd);
        n++;
      end
      if (rd[15] !== 1'b0) begin
        num_errors++;
        complete_run();
      end
      check16(rd, {1'b0, c[1:0], c[0], 3'h0, 9'h0a5 + c[8:0]});
      check16({8'h00, starts}, 16'(c + 1));
    end
    write_reg(5'h1d, 16'h0e00);
    read_reg(5'h1d, rd);
    check16(rd, {1'b0, 2'h3, 1'b1, 3'h7, 9'h0a8});
    check16({8'h00, starts}, 16'h0004);
  endtask

  // mid-run reset with enables, level, a flag and results all non-zero
  task automatic t_rerun;
    write_reg(5'h1b, 16'h0400);
    write_reg(5'h1f, 16'h0200);
    pulse(2);
    pin_after_edge(1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    sts   <= 3'h0;
    @(posedge clk);
    rst_n <= 1'b1;
    pin_after_edge(1'b1);
    t_reset();
  endtask

  // ------------------------------------------------------------
  // clock, reset and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    num_errors = 0;
    checked    = 0;
    rst_n      = 1'b0;
    reg_addr   = 5'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_wdata  = 16'h0000;
    evt        = 8'h00;
    sts        = 3'h0;
    delay      = 8'h03;
    code       = 2'h0;
    short_in   = 1'b0;
    count_in   = 9'h000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_access();
    t_flags();
    t_irq();
    t_status();
    t_diag();
    t_rerun();
    complete_run();
  end
endmodule
